// ===== common/vga_timing_pkg.sv
// package for the 640x480 raster timing generator
// assumes one pixel-rate clock feeding the generator
package vga_timing_pkg;
  localparam int h_cnt_w = 10;
  localparam int v_cnt_w = 10;
  localparam int rgb_w = 3;
  // horizontal, in pixel clocks
  localparam logic [9:0] h_visible_interval = 10'h280;
  localparam logic [9:0] h_front_porch_interval = 10'h010;
  localparam logic [9:0] h_sync_pulse_width = 10'h060;
  localparam logic [9:0] h_back_porch_interval = 10'h030;
  localparam logic [9:0] h_total = 10'h320;
  // vertical, in lines
  localparam logic [9:0] v_visible_interval = 10'h1E0;
  localparam logic [9:0] v_front_porch_interval = 10'h00A;
  localparam logic [9:0] v_sync_pulse_width = 10'h002;
  localparam logic [9:0] v_back_porch_interval = 10'h01D;
  localparam logic [9:0] v_total = 10'h209;
  localparam logic [2:0] rgb_black = 3'h0;
  localparam logic [9:0] cnt_zero = 10'h000;
  localparam logic [9:0] cnt_one = 10'h001;
  localparam int fifo_depth = 16;
endpackage

// ===== verilog/vga_timing_gen.sv
// 640x480 raster timing generator with a pixel data fifo
// assumes i_core_clk is the pixel clock; pixel source obeys valid/ready
// Overview of operation
// R1: advance one pixel position per pixel clock; 640x480 at about 60 Hz
// R2: each line is 800 clocks, the first 640 visible
// R3: horizontal sync 96 clocks, vertical sync 2 lines
// R4: horizontal front porch 16 clocks before sync, back porch 48 after
// R5: vertical front porch 10 lines before sync, back porch 29 after
// R6: each frame is 521 lines, 480 visible
// R7: colour outputs black during any porch or sync interval except the first front porch clock, which still shows the last visible pixel
// R8: pixel counter increments each clock; decoded into horizontal sync
// R9: row counter increments once per horizontal sync; decoded into vertical sync
// R10: both counters wrap freely and are exported as buffer address
// R11: counter origin at start of visible area to ease addressing
// R12: three one-bit colour outputs, all zero is black
// R13: both sync outputs active low, idle high
// R14: reset zeroes counters, releases syncs and forces black
`timescale 1ns/1ps

module pixel_fifo #(
  parameter int width = 3,
  parameter int depth = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [width-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [width-1:0] o_out_data
);
  localparam int aw = $clog2(depth);
  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [aw-1:0] wr;
    logic [aw-1:0] rd;
    logic [aw:0] cnt;
  } fifo_s;
  fifo_s q_r, q_nxt;
  logic push, pop;

  assign o_in_ready = 32'(q_r.cnt) != depth;
  assign o_out_valid = q_r.cnt != '0;
  assign o_out_data = q_r.mem[q_r.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    q_nxt = q_r;
    if (push)
    begin
      q_nxt.mem[q_r.wr] = i_in_data;
      q_nxt.wr = aw'(32'(q_r.wr) == depth - 1 ? 0 : 32'(q_r.wr) + 1);
    end
    if (pop)
      q_nxt.rd = aw'(32'(q_r.rd) == depth - 1 ? 0 : 32'(q_r.rd) + 1);
    if (push && !pop)
      q_nxt.cnt = q_r.cnt + 1'b1;
    else if (pop && !push)
      q_nxt.cnt = q_r.cnt - 1'b1;
    if (i_reset)
      q_nxt = '0;
  end

  always_ff @(posedge i_core_clk)
  begin
    q_r <= q_nxt;
  end
endmodule // pixel_fifo

module vga_timing_gen
  import vga_timing_pkg::*;
#(
  parameter int fifo_words = vga_timing_pkg::fifo_depth
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // pixel source
  input wire logic i_pix_valid,
  output logic o_pix_ready,
  input wire logic [vga_timing_pkg::rgb_w-1:0] i_pix_rgb,
  // display buffer address
  output logic [vga_timing_pkg::h_cnt_w-1:0] o_pixel_col,
  output logic [vga_timing_pkg::v_cnt_w-1:0] o_pixel_row,
  output logic o_visible,
  // monitor pins
  output logic o_horizontal_sync_pulse_n,
  output logic o_vertical_sync_pulse_n,
  output logic o_red,
  output logic o_green,
  output logic o_blue
);
  import vga_timing_pkg::*;

  typedef struct packed {
    logic [h_cnt_w-1:0] col;
    logic [v_cnt_w-1:0] row;
    logic hs_n;
    logic vs_n;
    logic [rgb_w-1:0] rgb;
  } gen_s;

  gen_s s_r, s_nxt;
  logic f_valid, f_take;
  logic [rgb_w-1:0] f_data;
  logic in_vis;

  // true while the count lies inside [start, start+width)
  function automatic logic in_win(input logic [9:0] c, input logic [9:0] st,
                                  input logic [9:0] w);
    in_win = (c >= st) && (c < st + w);
  endfunction

  pixel_fifo #(.width(rgb_w), .depth(fifo_words)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_in_valid(i_pix_valid),
    .o_in_ready(o_pix_ready),
    .i_in_data(i_pix_rgb),
    .o_out_valid(f_valid),
    .i_out_ready(f_take),
    .o_out_data(f_data)
  );

  assign in_vis = (s_r.col < h_visible_interval) && (s_r.row < v_visible_interval); // R11
  assign f_take = in_vis; // R1
  assign o_visible = in_vis;
  assign o_pixel_col = s_r.col; // R10
  assign o_pixel_row = s_r.row; // R10
  assign o_horizontal_sync_pulse_n = s_r.hs_n;
  assign o_vertical_sync_pulse_n = s_r.vs_n;
  assign o_red = s_r.rgb[2]; // R12
  assign o_green = s_r.rgb[1];
  assign o_blue = s_r.rgb[0];

  always_comb
  begin
    s_nxt = s_r;
    // pixel counter, wraps after 800 clocks
    if (s_r.col == h_total - cnt_one) // R2 R8
    begin
      s_nxt.col = cnt_zero;
      // row counter, wraps after 521 lines
      if (s_r.row == v_total - cnt_one) // R6 R9
        s_nxt.row = cnt_zero;
      else
        s_nxt.row = s_r.row + cnt_one;
    end
    else
      s_nxt.col = s_r.col + cnt_one; // R1
    // sync decode: visible, front porch, sync, back porch
    s_nxt.hs_n = !in_win(s_nxt.col, h_visible_interval + h_front_porch_interval,
                         h_sync_pulse_width); // R3 R4 R8 R13
    s_nxt.vs_n = !in_win(s_nxt.row, v_visible_interval + v_front_porch_interval,
                         v_sync_pulse_width); // R3 R5 R9 R13
    // colour follows counter by one clock, black in blanking or on underrun
    s_nxt.rgb = (in_vis && f_valid) ? f_data : rgb_black; // R7
    if (i_reset)
    begin
      s_nxt.col = cnt_zero; // R14
      s_nxt.row = cnt_zero;
      s_nxt.hs_n = 1'b1;
      s_nxt.vs_n = 1'b1;
      s_nxt.rgb = rgb_black;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    s_r <= s_nxt;
  end
endmodule // vga_timing_gen

// ===== bench/vga_timing_gen_assertions.sv
// port checks for the raster generator
// bound into vga_timing_gen
`timescale 1ns/1ps
module vga_chk (
  input logic i_core_clk,
  input logic i_reset,
  input logic [9:0] o_pixel_col,
  input logic [9:0] o_pixel_row,
  input logic o_visible,
  input logic o_horizontal_sync_pulse_n,
  input logic o_vertical_sync_pulse_n,
  input logic o_red,
  input logic o_green,
  input logic o_blue
);
  wire [9:0] c = o_pixel_col;
  wire [9:0] r = o_pixel_row;
  wire e = c == 10'h31F;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_wrap; e ##1 c == 10'h000; endsequence
  property p_hs; o_horizontal_sync_pulse_n != (c inside {[10'h290:10'h2EF]}); endproperty
  property p_vs; o_vertical_sync_pulse_n != (r inside {[10'h1EA:10'h1EB]}); endproperty
  property p_inc; !e |=> c == $past(c) + 10'h001; endproperty
  property p_wrap; e |-> s_wrap; endproperty
  property p_row; !e |=> $stable(r); endproperty
  property p_vis; o_visible == (c < 10'h280 && r < 10'h1E0); endproperty
  property p_blank; !o_visible |=> {o_red, o_green, o_blue} == 3'h0; endproperty
  property p_rst; $fell(i_reset) |-> (c | r) == 10'h000 && o_vertical_sync_pulse_n; endproperty
  a_hs: assert property (p_hs) else $error("hsync");
  a_vs: assert property (p_vs) else $error("vsync");
  a_inc: assert property (p_inc) else $error("col");
  a_wrap: assert property (p_wrap) else $error("wrap");
  a_row: assert property (p_row) else $error("row");
  a_vis: assert property (p_vis) else $error("vis");
  a_blank: assert property (p_blank) else $error("blank");
  a_rst: assert property (p_rst) else $error("reset");
endmodule // vga_chk
bind vga_timing_gen vga_chk u_chk (.*);

// ===== bench/vga_monitor.sv
// display model: horizontal sync low time
// assumes an active low sync pin
`timescale 1ns/1ps
module vga_monitor (
  input logic i_core_clk,
  input logic i_hsync_n,
  output int o_width
);
  int low;
  always @(posedge i_core_clk)
  begin
    low <= i_hsync_n ? 0 : low + 1;
    if (i_hsync_n && low != 0)
      o_width <= low;
  end
endmodule // vga_monitor

// ===== bench/tb.sv
// bench for the raster generator
// one clock; monitor on horizontal sync
`timescale 1ns/1ps
module tb;
  logic i_core_clk = 1'h0, i_reset = 1'h1, i_pix_valid = 1'h0;
  logic [2:0] i_pix_rgb = 3'h0;
  logic [9:0] o_pixel_col, o_pixel_row;
  logic o_pix_ready, o_visible, o_red, o_green, o_blue;
  logic o_horizontal_sync_pulse_n, o_vertical_sync_pulse_n;
  int o_width, error_cnt, checks_done;
  wire [9:0] pins = {4'h0, o_horizontal_sync_pulse_n,
    o_vertical_sync_pulse_n, o_red, o_green, o_blue, o_pix_ready};
  always #4 i_core_clk = ~i_core_clk;
  vga_timing_gen uut (.*);
  vga_monitor mon (.i_core_clk, .i_hsync_n(o_horizontal_sync_pulse_n), .o_width);
  task chk(input string n, input logic [9:0] s, input logic [9:0] e);
    checks_done++;
    error_cnt += (s !== e);
    if (s !== e)
      $display("wrong value %s expected %h seen %h", n, e, s);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wait_col(input logic [9:0] v);
    for (int n = 0; n < 2000 && o_pixel_col !== v; n++)
      @(negedge i_core_clk);
  endtask
  task t_reset;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk("cnt", o_pixel_col | o_pixel_row, 10'h000);
    chk("pins", pins, 10'h031);
    repeat (10) @(posedge i_core_clk);
    i_reset <= 1'h0;
    $display("reset test done");
  endtask
  task t_pixels;
    wait_col(10'h300);
    for (int k = 0; k < 18; k++)
    begin
      @(posedge i_core_clk);
      i_pix_valid <= k < 17;
      i_pix_rgb <= k[2:0] | {3{k > 15}};
    end
    @(negedge i_core_clk);
    chk("full", pins, 10'h030);
    wait_col(10'h001);
    chk("row", o_pixel_row, 10'h001);
    for (int k = 0; k < 18; k++)
    begin
      chk("pix", pins, {6'h03, k[2:0] & {3{k < 16}}, 1'h1});
      @(negedge i_core_clk);
    end
    wait_col(10'h2F0);
    chk("width", o_width[9:0], 10'h060);
    chk("porch", pins, 10'h031);
    $display("pixel test done");
  endtask
  initial
  begin
    t_reset;
    t_pixels;
    stop_test;
  end
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    error_cnt++;
    stop_test;
  end
endmodule // tb
